// file: core/nes_pkg.sv
// Constants for the nonvolatile-memory integrity status registers
package nes_pkg;
    // Register addresses on the byte-wide host register port
    localparam logic [7:0] ADDR_UNCORR   = 8'h5B;
    localparam logic [7:0] ADDR_EE_DET   = 8'h5C;
    localparam logic [7:0] ADDR_NVM_ERR  = 8'h5E;
    localparam logic [7:0] ADDR_SS_CFG_A = 8'h60;

    // Field positions
    localparam int NVM_CLR_BIT    = 4;
    localparam int DATA_VALID_BIT = 1;
    localparam int VOLT_FAULT_BIT = 0;
    localparam int SS_FREQ_LSB    = 6;
    localparam int SS_FREQ_MSB    = 7;

    // Reset values
    localparam logic [7:0] RST_UNCORR = 8'h00;
    localparam logic [7:0] RST_EE_DET = 8'h00;
    localparam logic [7:0] RST_SS_CFG = 8'h00;

    // Modulation frequency select codes
    typedef enum logic [1:0] {
        NES_SS_17K5,
        NES_SS_20K,
        NES_SS_22K5,
        NES_SS_25K
    } nes_ss_freq_t;

    // Clock and modulation frequencies in Hz
    localparam int CLK_HZ     = 200_000_000;
    localparam int SS_HZ_17K5 = 17_500;
    localparam int SS_HZ_20K  = 20_000;
    localparam int SS_HZ_22K5 = 22_500;
    localparam int SS_HZ_25K  = 25_000;

    // Modulation periods in clock cycles, rounded down
    localparam int SS_CYC_17K5 = CLK_HZ / SS_HZ_17K5;
    localparam int SS_CYC_20K  = CLK_HZ / SS_HZ_20K;
    localparam int SS_CYC_22K5 = CLK_HZ / SS_HZ_22K5;
    localparam int SS_CYC_25K  = CLK_HZ / SS_HZ_25K;

    localparam int SS_CNT_W = 16;
endpackage : nes_pkg

// file: core/nes_flag_bank.sv
// Sticky status flags: set by hardware, cleared together by software
`timescale 1ns/1ps
`default_nettype none
module nes_flag_bank #(
    parameter int         W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set_evt,
    input  wire logic         clr,
    output logic      [W-1:0] flags_r
);
    logic [W-1:0] flags_nxt;

    // Set wins over clear so an event in the clearing cycle survives
    always_comb begin
        flags_nxt = (flags_r & ~{W{clr}}) | set_evt;
    end

    // Flags only fall on the clearing write or at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= RST_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule : nes_flag_bank
`default_nettype wire

// file: core/nes_regs.sv
// Nonvolatile-memory integrity status and spread-spectrum config registers
//
// Functional notes
// - One uncorrectable-ECC flag per bank, bank n in bit n, one means error.
// - Writing one to bit four at 0x5E clears all these status flags.
// - Data-valid bit one reads set while either ID register is non-zero.
// - Bit zero latches insufficient EEPROM supply voltage, zero when normal.
// - Uncorrectable flag register resets to all zeros.
// - Bits seven and six select modulation frequency; reset 00 means 17.5kHz.
`timescale 1ns/1ps
`default_nettype none
module nes_regs #(
    parameter int SS_PERIOD_17K5 = nes_pkg::SS_CYC_17K5,
    parameter int SS_PERIOD_20K  = nes_pkg::SS_CYC_20K,
    parameter int SS_PERIOD_22K5 = nes_pkg::SS_CYC_22K5,
    parameter int SS_PERIOD_25K  = nes_pkg::SS_CYC_25K
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_r,
    output logic            reg_rvalid_r,
    input  wire logic [7:0] ecc_uncorr_evt,
    input  wire logic       prog_voltage_low,
    input  wire logic [7:0] eeprom_id1,
    input  wire logic [7:0] eeprom_id2,
    output logic      [7:0] uncorr_flags_r,
    output logic            customer_data_valid_r,
    output logic            prog_voltage_fault_latched_r,
    output logic      [7:0] ss_cfg_r,
    output logic            ss_mod_tick_r
);
    localparam int CW = nes_pkg::SS_CNT_W;

    logic            rst_meta_r;
    logic            rst_sync_r;
    logic            nonvolatile_fault_clear;
    logic            data_valid_set;
    logic [1:0]      detail_flags_r;
    logic [7:0]      rdata_nxt;
    logic [CW-1:0]   ss_cnt_r;
    logic [CW-1:0]   ss_cnt_nxt;
    logic [CW-1:0]   ss_period;

    // Modulation period in cycles for a select code
    function automatic logic [CW-1:0] ss_period_of(input logic [1:0] sel);
        logic [CW-1:0] p;
        p = '0;
        unique case (nes_pkg::nes_ss_freq_t'(sel))
            nes_pkg::NES_SS_17K5: p = CW'(SS_PERIOD_17K5);
            nes_pkg::NES_SS_20K:  p = CW'(SS_PERIOD_20K);
            nes_pkg::NES_SS_22K5: p = CW'(SS_PERIOD_22K5);
            nes_pkg::NES_SS_25K:  p = CW'(SS_PERIOD_25K);
        endcase
        return p;
    endfunction : ss_period_of

    // Reset release through two flops; assertion is still immediate
    // Costs two cycles of release latency but keeps release clear of the clock edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Clearing strobe: write of one to the clear bit; bit is not stored
    assign nonvolatile_fault_clear = reg_wr_en && (reg_addr == nes_pkg::ADDR_NVM_ERR)
                                     && reg_wdata[nes_pkg::NVM_CLR_BIT];

    // Valid is held set while an ID is non-zero, so a clear only sticks once both are zero
    assign data_valid_set = (eeprom_id1 != 8'h00) || (eeprom_id2 != 8'h00);

    // Per-bank uncorrectable error flags
    nes_flag_bank #(
        .W       (8),
        .RST_VAL (nes_pkg::RST_UNCORR)
    ) u_uncorr (
        .clk     (ref_clk),
        .rst_n   (rst_sync_r),
        .set_evt (ecc_uncorr_evt),
        .clr     (nonvolatile_fault_clear),
        .flags_r (uncorr_flags_r)
    );

    // Detail flags: bit one data valid, bit zero supply fault
    nes_flag_bank #(
        .W       (2),
        .RST_VAL (nes_pkg::RST_EE_DET[1:0])
    ) u_detail (
        .clk     (ref_clk),
        .rst_n   (rst_sync_r),
        .set_evt ({data_valid_set, prog_voltage_low}),
        .clr     (nonvolatile_fault_clear),
        .flags_r (detail_flags_r)
    );

    assign customer_data_valid_r        = detail_flags_r[nes_pkg::DATA_VALID_BIT];
    assign prog_voltage_fault_latched_r = detail_flags_r[nes_pkg::VOLT_FAULT_BIT];

    // Spread-spectrum config, plain read/write byte
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ss_cfg_r <= nes_pkg::RST_SS_CFG;
        end else if (reg_wr_en && reg_addr == nes_pkg::ADDR_SS_CFG_A) begin
            ss_cfg_r <= reg_wdata;
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            nes_pkg::ADDR_UNCORR:   rdata_nxt = uncorr_flags_r;
            nes_pkg::ADDR_EE_DET:   rdata_nxt = {6'h00, detail_flags_r};
            nes_pkg::ADDR_SS_CFG_A: rdata_nxt = ss_cfg_r;
            default:                rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reg_rdata_r  <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

    // Modulation tick; a select change applies to the running count in the cycle after the write
    assign ss_period = ss_period_of(ss_cfg_r[nes_pkg::SS_FREQ_MSB:nes_pkg::SS_FREQ_LSB]);

    // Next count; wrapping at or past the end also catches a shortened period
    always_comb begin
        if (ss_cnt_r >= ss_period - CW'(1)) begin
            ss_cnt_nxt = '0;
        end else begin
            ss_cnt_nxt = ss_cnt_r + CW'(1);
        end
    end

    // Tick registered with the count so it marks the first cycle after a wrap
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ss_cnt_r      <= '0;
            ss_mod_tick_r <= 1'b0;
        end else begin
            ss_cnt_r      <= ss_cnt_nxt;
            ss_mod_tick_r <= (ss_cnt_nxt == '0);
        end
    end

    // Checks
    a_clear_uncorr: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        nonvolatile_fault_clear && ecc_uncorr_evt == 8'h00 |=> uncorr_flags_r == 8'h00)
        else $error("uncorrectable flags not cleared");

    a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        nonvolatile_fault_clear && prog_voltage_low |=> prog_voltage_fault_latched_r)
        else $error("supply fault lost in clearing cycle");

    a_flags_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !nonvolatile_fault_clear |=> (($past(uncorr_flags_r) & ~uncorr_flags_r) == 8'h00))
        else $error("uncorrectable flag fell without clear");

    a_fault_sticky: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        !nonvolatile_fault_clear |=> !$fell(prog_voltage_fault_latched_r)
                                     && !$fell(customer_data_valid_r))
        else $error("detail flag fell without clear");

    a_clear_detail: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        nonvolatile_fault_clear && !prog_voltage_low && !data_valid_set
            |=> !prog_voltage_fault_latched_r && !customer_data_valid_r)
        else $error("detail flags not cleared");

    a_bank_sets: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        ecc_uncorr_evt != 8'h00 |=> (uncorr_flags_r & $past(ecc_uncorr_evt))
                                     == $past(ecc_uncorr_evt))
        else $error("bank flag not set");

    a_valid_follows: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        data_valid_set |=> customer_data_valid_r)
        else $error("data valid not set for non-zero id");

    a_volt_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        prog_voltage_low ##1 !nonvolatile_fault_clear [*3] |=> prog_voltage_fault_latched_r)
        else $error("supply fault not held");

    a_detail_upper: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        reg_rd_en && reg_addr == nes_pkg::ADDR_EE_DET |=> reg_rvalid_r
                                                        && reg_rdata_r[7:2] == 6'h00)
        else $error("unused detail bits not zero");

    a_reset_zero: assert property (@(posedge ref_clk)
        $rose(rst_sync_r) |-> uncorr_flags_r == 8'h00 && ss_cfg_r[7:6] == 2'b00)
        else $error("reset values wrong");

    a_tick_bound: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
        $stable(ss_cfg_r[nes_pkg::SS_FREQ_MSB:nes_pkg::SS_FREQ_LSB]) |-> ss_cnt_r < ss_period)
        else $error("modulation counter out of range");

    c_clear: cover property (@(posedge ref_clk) disable iff (!rst_sync_r)
        uncorr_flags_r != 8'h00 ##1 nonvolatile_fault_clear);
    c_set_clear: cover property (@(posedge ref_clk) disable iff (!rst_sync_r)
        nonvolatile_fault_clear && ecc_uncorr_evt != 8'h00);
    c_ss_write: cover property (@(posedge ref_clk) disable iff (!rst_sync_r)
        reg_wr_en && reg_addr == nes_pkg::ADDR_SS_CFG_A && reg_wdata[7:6] == 2'b11);
    c_valid_kept: cover property (@(posedge ref_clk) disable iff (!rst_sync_r)
        nonvolatile_fault_clear && data_valid_set);
endmodule : nes_regs
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the integrity status and spread config registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int P_SLOW = 8;
    localparam int P_SEL1 = 10;
    localparam int P_SEL2 = 12;
    localparam int P_FAST = 14;

    typedef struct packed {
        logic [7:0] evt;
        logic       volt;
        logic [7:0] id1;
        logic [7:0] id2;
        logic [7:0] exp_flags;
        logic [7:0] exp_det;
    } nes_row_t;

    logic       ref_clk          = 1'b0;
    logic       rst_n            = 1'b0;
    logic       reg_wr_en        = 1'b0;
    logic       reg_rd_en        = 1'b0;
    logic [7:0] reg_addr         = 8'h00;
    logic [7:0] reg_wdata        = 8'h00;
    logic [7:0] ecc_uncorr_evt   = 8'h00;
    logic       prog_voltage_low = 1'b0;
    logic [7:0] eeprom_id1       = 8'h00;
    logic [7:0] eeprom_id2       = 8'h00;
    logic [7:0] reg_rdata_r, uncorr_flags_r, ss_cfg_r;
    logic       reg_rvalid_r, customer_data_valid_r, prog_voltage_fault_latched_r;
    logic       ss_mod_tick_r;
    logic [7:0] det_pins;
    int         err_total        = 0;
    int         checks_done      = 0;

    // Events, supply fault and ID values with the flags they should leave
    nes_row_t rows [5] = '{
        '{8'h01, 1'b0, 8'h00, 8'h00, 8'h01, 8'h00},
        '{8'h80, 1'b1, 8'h00, 8'h00, 8'h80, 8'h01},
        '{8'hA5, 1'b0, 8'h01, 8'h00, 8'hA5, 8'h02},
        '{8'h00, 1'b0, 8'h00, 8'h80, 8'h00, 8'h02},
        '{8'hFF, 1'b1, 8'hFF, 8'h00, 8'hFF, 8'h03}
    };

    // Short modulation periods keep the tick checks quick
    // Detail flag pins packed like the detail register
    assign det_pins = {6'h00, customer_data_valid_r, prog_voltage_fault_latched_r};

    nes_regs #(.SS_PERIOD_17K5(P_SLOW), .SS_PERIOD_20K(P_SEL1), .SS_PERIOD_22K5(P_SEL2),
               .SS_PERIOD_25K(P_FAST)) nes_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .ecc_uncorr_evt(ecc_uncorr_evt),
        .prog_voltage_low(prog_voltage_low), .eeprom_id1(eeprom_id1),
        .eeprom_id2(eeprom_id2), .uncorr_flags_r(uncorr_flags_r),
        .customer_data_valid_r(customer_data_valid_r),
        .prog_voltage_fault_latched_r(prog_voltage_fault_latched_r),
        .ss_cfg_r(ss_cfg_r), .ss_mod_tick_r(ss_mod_tick_r));

    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task report_and_stop;
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One-cycle write strobe, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // Read answer lands at the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        check({nm, " valid"}, {7'h00, reg_rvalid_r}, 8'h01);
        check(nm, reg_rdata_r, exp);
        @(posedge ref_clk);
        #1;
        check({nm, " valid end"}, {7'h00, reg_rvalid_r}, 8'h00);
    endtask : rd

    // Cycles up to the next tick; bounded so a dead counter cannot hang the run
    task automatic tick_wait(output int g);
        g = 0;
        do begin
            @(posedge ref_clk);
            #1;
            g++;
        end while (ss_mod_tick_r !== 1'b1 && g < 100);
        if (g >= 100) begin
            err_total++;
            report_and_stop();
        end
    endtask : tick_wait

    // Third gap is clear of any select change still settling
    task automatic gap(input logic [7:0] exp);
        int g;
        tick_wait(g);
        tick_wait(g);
        tick_wait(g);
        check("tick gap", g[7:0], exp);
    endtask : gap

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Ordinary cases: raise, read back, then clear
        foreach (rows[i]) begin
            @(posedge ref_clk);
            ecc_uncorr_evt   <= rows[i].evt;
            prog_voltage_low <= rows[i].volt;
            eeprom_id1       <= rows[i].id1;
            eeprom_id2       <= rows[i].id2;
            @(posedge ref_clk);
            ecc_uncorr_evt   <= 8'h00;
            prog_voltage_low <= 1'b0;
            rd(nes_pkg::ADDR_UNCORR, "flags", rows[i].exp_flags);
            rd(nes_pkg::ADDR_EE_DET, "detail", rows[i].exp_det);
            check("detail pins", det_pins, rows[i].exp_det);
            @(posedge ref_clk);
            eeprom_id1 <= 8'h00;
            eeprom_id2 <= 8'h00;
            wr(nes_pkg::ADDR_NVM_ERR, 8'h10);
            rd(nes_pkg::ADDR_UNCORR, "flags cleared", 8'h00);
            rd(nes_pkg::ADDR_EE_DET, "detail cleared", 8'h00);
            check("detail pins cleared", det_pins, 8'h00);
        end
        // A clear while an ID is still non-zero leaves data valid standing
        @(posedge ref_clk);
        eeprom_id1 <= 8'h5A;
        wr(nes_pkg::ADDR_NVM_ERR, 8'h10);
        rd(nes_pkg::ADDR_EE_DET, "valid kept", 8'h02);
        @(posedge ref_clk);
        eeprom_id1 <= 8'h00;
        wr(nes_pkg::ADDR_NVM_ERR, 8'h10);
        rd(nes_pkg::ADDR_EE_DET, "valid cleared", 8'h00);
        // Flags survive idle time, a clear byte without bit four and ignored writes
        @(posedge ref_clk);
        ecc_uncorr_evt <= 8'h24;
        @(posedge ref_clk);
        ecc_uncorr_evt <= 8'h00;
        repeat (20) @(posedge ref_clk);
        wr(nes_pkg::ADDR_NVM_ERR, 8'hEF);
        wr(nes_pkg::ADDR_UNCORR, 8'hFF);
        wr(nes_pkg::ADDR_EE_DET, 8'hFF);
        rd(nes_pkg::ADDR_UNCORR, "sticky flags", 8'h24);
        rd(nes_pkg::ADDR_EE_DET, "unused detail bits", 8'h00);
        rd(8'h5D, "unmapped", 8'h00);
        // Clear meeting a new event in the same cycle keeps only the new one
        @(posedge ref_clk);
        reg_wr_en      <= 1'b1;
        reg_addr       <= nes_pkg::ADDR_NVM_ERR;
        reg_wdata      <= 8'h10;
        ecc_uncorr_evt <= 8'h08;
        @(posedge ref_clk);
        reg_wr_en      <= 1'b0;
        ecc_uncorr_evt <= 8'h00;
        #1;
        check("clear with event", uncorr_flags_r, 8'h08);
        // Frequency select: reset code, then the other three codes
        gap(8'(P_SLOW));
        wr(nes_pkg::ADDR_SS_CFG_A, 8'hC0);
        rd(nes_pkg::ADDR_SS_CFG_A, "spread cfg", 8'hC0);
        check("cfg pins", ss_cfg_r, 8'hC0);
        gap(8'(P_FAST));
        wr(nes_pkg::ADDR_SS_CFG_A, 8'h40);
        gap(8'(P_SEL1));
        wr(nes_pkg::ADDR_SS_CFG_A, 8'h80);
        gap(8'(P_SEL2));
        // Reset in mid-run wipes flags and config at once
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1;
        check("flags in reset", uncorr_flags_r, 8'h00);
        check("cfg in reset", ss_cfg_r, 8'h00);
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(nes_pkg::ADDR_UNCORR, "flags after reset", 8'h00);
        rd(nes_pkg::ADDR_SS_CFG_A, "cfg after reset", 8'h00);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
